// ===== rtl/csda_pkg.sv
package csda_pkg;

   // register byte offsets on the bus
   localparam logic [7:0] OFF_CTRL   = 8'h00;
   localparam logic [7:0] OFF_WORK   = 8'h04;
   localparam logic [7:0] OFF_FLAGS  = 8'h08;
   localparam logic [7:0] OFF_BANK   = 8'h0C;
   localparam logic [7:0] OFF_INDEX  = 8'h10;
   localparam logic [7:0] OFF_STATE  = 8'h14;
   localparam logic [7:0] OFF_SKIPS  = 8'h18;

   // field positions
   localparam int CTRL_EXT_BIT    = 0;
   localparam int FLAG_C_BIT      = 0;
   localparam int FLAG_DC_BIT     = 1;
   localparam int STATE_BUSY_BIT  = 0;
   localparam int STATE_SKIP_BIT  = 1;
   localparam int STATE_OPND_LSB  = 8;

   // reset values
   localparam logic [7:0]  RST_WORK  = 8'h00;
   localparam logic [3:0]  RST_BANK  = 4'h0;
   localparam logic [11:0] RST_INDEX = 12'h000;

   // bus answers
   localparam logic [1:0] RESP_OKAY   = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;

   // instruction encodings, upper seven bits of the word for compares
   localparam logic [6:0]  OPC_LESS    = 7'h30;
   localparam logic [6:0]  OPC_EQUAL   = 7'h31;
   localparam logic [6:0]  OPC_GREATER = 7'h32;
   localparam logic [15:0] WORD_DAW    = 16'h0007;

   // decimal adjust and addressing figures
   localparam logic [3:0] BCD_LIMIT        = 4'h9;
   localparam logic [3:0] BCD_FIX          = 4'h6;
   localparam logic [7:0] INDEXED_MAX      = 8'h5F;
   localparam logic [3:0] ACCESS_HIGH_BANK = 4'hF;

   // skip lengths in instruction cycles
   localparam logic [1:0] NOP_ONE_WORD = 2'd1;
   localparam logic [1:0] NOP_TWO_WORD = 2'd2;

   // default sys_clk cycles per quarter phase
   localparam int Q_DIV_DEFAULT = 4;

   typedef enum logic [1:0] {Q_ONE, Q_TWO, Q_THREE, Q_FOUR} csda_phase_type;
   typedef enum logic [2:0] {OP_NONE, OP_LESS, OP_EQUAL, OP_GREATER, OP_DAW} csda_op_type;
   typedef enum logic [1:0] {S_IDLE, S_EXEC, S_SKIP} csda_state_type;

   typedef struct packed {
      logic        valid;
      logic [15:0] word;
      logic        nextTwoWord;
   } csda_instr_type;

   typedef struct packed {
      logic        ready;
      logic        discard;
      logic        busy;
      logic        memRdEn;
      logic [11:0] memAddr;
   } csda_pipe_type;

endpackage

// ===== rtl/csda_qphase.sv
`timescale 1ns/10ps
module csda_qphase #(
   parameter int DIV = 4
) (
   input  wire logic                     sys_clk,
   input  wire logic                     rst,
   output logic                          qTick,
   output csda_pkg::csda_phase_type      qPhase
);
   import csda_pkg::*;

   logic [15:0] divCnt_r;

   // one enable pulse every DIV clocks
   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         divCnt_r <= 16'h0000;
         qTick    <= 1'b0;
      end
      else
      begin
         qTick <= (divCnt_r == 16'(DIV - 1));
         if (divCnt_r == 16'(DIV - 1))
            divCnt_r <= 16'h0000;
         else
            divCnt_r <= divCnt_r + 16'h0001;
      end
   end

   // phase shown during a tick is the phase that tick executes
   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
         qPhase <= Q_ONE;
      else if (qTick)
      begin
         case (qPhase)
            Q_ONE:   qPhase <= Q_TWO;
            Q_TWO:   qPhase <= Q_THREE;
            Q_THREE: qPhase <= Q_FOUR;
            default: qPhase <= Q_ONE;
         endcase
      end
   end

endmodule

// ===== rtl/csda_alu.sv
`timescale 1ns/10ps
module csda_alu (
   input  csda_pkg::csda_op_type  op,
   input  wire logic [7:0]        fileVal,
   input  wire logic [7:0]        work,
   input  wire logic              carry,
   input  wire logic              digitCarry,
   output logic                   skipHit,
   output logic [7:0]             dawValue,
   output logic                   dawCarry
);
   import csda_pkg::*;

   logic [8:0] diff;
   logic       borrow;
   logic       zero;
   logic [3:0] loNib;
   logic [4:0] hiSum;
   logic [4:0] hiRes;

   // unsigned subtraction, difference only steers the skip
   assign diff   = {1'b0, fileVal} - {1'b0, work};
   assign borrow = diff[8];
   assign zero   = (diff[7:0] == 8'h00);

   always_comb
   begin
      case (op)
         OP_EQUAL:   skipHit = zero;
         OP_GREATER: skipHit = !borrow && !zero;
         OP_LESS:    skipHit = borrow;
         default:    skipHit = 1'b0;
      endcase
   end

   // low nibble fix
   assign loNib = ((work[3:0] > BCD_LIMIT) || digitCarry)
                  ? 4'(work[3:0] + BCD_FIX) : work[3:0];

   // high nibble takes digit carry, plus six when over nine or carry set
   assign hiSum = {1'b0, work[7:4]} + {4'h0, digitCarry};
   assign hiRes = ((hiSum > {1'b0, BCD_LIMIT}) || carry)
                  ? 5'(hiSum + {1'b0, BCD_FIX}) : hiSum;

   assign dawValue = {hiRes[3:0], loNib};
   assign dawCarry = hiRes[4] | carry;

endmodule

// ===== rtl/csda_core.sv
// Notes on behaviour
// - equal compare skips next instruction when file equals working register; flags untouched.
// - greater compare skips only when file, unsigned, exceeds working register; flags untouched.
// - less compare skips only when file, unsigned, is below working register; flags untouched.
// - skip discards fetched instruction, runs one nop cycle; compare takes one cycle, two or three when it skips.
// - skip over a two-word instruction totals three cycles; skipped cycles do nothing.
// - access bit 0 picks access bank; access bit 1 picks bank from bank select.
// - access bit 0, extended set on, file at most 95: indexed literal offset address.
// - decimal adjust adds six to low nibble if above nine or digit carry; one cycle.
// - high nibble gets digit carry, plus six if sum above nine or carry; carry updated.
`timescale 1ns/10ps
module csda_core #(
   parameter int Q_DIV = csda_pkg::Q_DIV_DEFAULT
) (
   input  wire logic                sys_clk,
   input  wire logic                rst,
   input  wire logic [7:0]          s_axi_awaddr,
   input  wire logic                s_axi_awvalid,
   output logic                     s_axi_awready,
   input  wire logic [31:0]         s_axi_wdata,
   input  wire logic [3:0]          s_axi_wstrb,
   input  wire logic                s_axi_wvalid,
   output logic                     s_axi_wready,
   output logic [1:0]               s_axi_bresp,
   output logic                     s_axi_bvalid,
   input  wire logic                s_axi_bready,
   input  wire logic [7:0]          s_axi_araddr,
   input  wire logic                s_axi_arvalid,
   output logic                     s_axi_arready,
   output logic [31:0]              s_axi_rdata,
   output logic [1:0]               s_axi_rresp,
   output logic                     s_axi_rvalid,
   input  wire logic                s_axi_rready,
   input  csda_pkg::csda_instr_type instrIn,
   output csda_pkg::csda_pipe_type  pipeOut,
   input  wire logic [7:0]          memRdData
);
   import csda_pkg::*;

   logic           qTick;
   csda_phase_type qPhase;
   logic           awHeld_r;
   logic           wHeld_r;
   logic [7:0]     awAddr_r;
   logic [31:0]    wData_r;
   logic [3:0]     wStrb_r;
   logic           doWrite;
   logic           wrHit;
   logic [31:0]    rdMux;
   logic           rdHit;
   logic           extEn_r;
   logic [7:0]     work_r;
   logic           carry_r;
   logic           digitCarry_r;
   logic [3:0]     bank_r;
   logic [11:0]    indexBase_r;
   logic [15:0]    skipCount_r;
   logic           lastSkip_r;
   logic [7:0]     operand_r;
   csda_state_type state_r;
   csda_op_type    op_r;
   csda_op_type    opDecoded;
   logic [7:0]     file_r;
   logic           access_r;
   logic           twoWord_r;
   logic [1:0]     nopLeft_r;
   logic [11:0]    effAddr;
   logic           skipHit;
   logic [7:0]     dawValue;
   logic           dawCarry;
   logic           isCompare;
   logic           decide;
   logic           dawCommit;

   function automatic logic [31:0] mergeLanes(input logic [31:0] oldVal,
                                              input logic [31:0] newVal,
                                              input logic [3:0]  strb);
      logic [31:0] mask;
      mask = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
      return (oldVal & ~mask) | (newVal & mask);
   endfunction

   csda_qphase #(
      .DIV (Q_DIV)
   ) u_qphase (
      .sys_clk (sys_clk),
      .rst     (rst),
      .qTick   (qTick),
      .qPhase  (qPhase)
   );

   csda_alu u_alu (
      .op         (op_r),
      .fileVal    (operand_r),
      .work       (work_r),
      .carry      (carry_r),
      .digitCarry (digitCarry_r),
      .skipHit    (skipHit),
      .dawValue   (dawValue),
      .dawCarry   (dawCarry)
   );

   // bus write channels: address and data in either order
   assign doWrite = awHeld_r && wHeld_r && !s_axi_bvalid;
   assign wrHit   = (awAddr_r == OFF_CTRL) || (awAddr_r == OFF_WORK)
                    || (awAddr_r == OFF_FLAGS) || (awAddr_r == OFF_BANK)
                    || (awAddr_r == OFF_INDEX) || (awAddr_r == OFF_STATE)
                    || (awAddr_r == OFF_SKIPS);

   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         awHeld_r      <= 1'b0;
         wHeld_r       <= 1'b0;
         awAddr_r      <= 8'h00;
         wData_r       <= 32'h0000_0000;
         wStrb_r       <= 4'h0;
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= RESP_OKAY;
      end
      else
      begin
         if (s_axi_awvalid && s_axi_awready)
         begin
            awHeld_r      <= 1'b1;
            awAddr_r      <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
         end
         else if (!awHeld_r && !s_axi_bvalid)
            s_axi_awready <= 1'b1;
         if (s_axi_wvalid && s_axi_wready)
         begin
            wHeld_r      <= 1'b1;
            wData_r      <= s_axi_wdata;
            wStrb_r      <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
         end
         else if (!wHeld_r && !s_axi_bvalid)
            s_axi_wready <= 1'b1;
         if (doWrite)
         begin
            awHeld_r     <= 1'b0;
            wHeld_r      <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wrHit ? RESP_OKAY : RESP_SLVERR;
         end
         else if (s_axi_bvalid && s_axi_bready)
            s_axi_bvalid <= 1'b0;
      end
   end

   // read mux
   always_comb
   begin
      rdMux = 32'h0000_0000;
      rdHit = 1'b1;
      case (s_axi_araddr)
         OFF_CTRL:  rdMux[CTRL_EXT_BIT] = extEn_r;
         OFF_WORK:  rdMux[7:0] = work_r;
         OFF_FLAGS:
         begin
            rdMux[FLAG_C_BIT]  = carry_r;
            rdMux[FLAG_DC_BIT] = digitCarry_r;
         end
         OFF_BANK:  rdMux[3:0] = bank_r;
         OFF_INDEX: rdMux[11:0] = indexBase_r;
         OFF_STATE:
         begin
            rdMux[STATE_BUSY_BIT] = (state_r != S_IDLE);
            rdMux[STATE_SKIP_BIT] = lastSkip_r;
            rdMux[STATE_OPND_LSB +: 8] = operand_r;
         end
         OFF_SKIPS: rdMux[15:0] = skipCount_r;
         default:   rdHit = 1'b0;
      endcase
   end

   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= RESP_OKAY;
      end
      else if (s_axi_arvalid && s_axi_arready)
      begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b1;
         s_axi_rdata   <= rdMux;
         s_axi_rresp   <= rdHit ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_rvalid && s_axi_rready)
      begin
         s_axi_rvalid  <= 1'b0;
         s_axi_arready <= 1'b1;
      end
      else if (!s_axi_rvalid)
         s_axi_arready <= 1'b1;
   end

   // software settings
   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         extEn_r     <= 1'b0;
         bank_r      <= RST_BANK;
         indexBase_r <= RST_INDEX;
      end
      else if (doWrite)
      begin
         if (awAddr_r == OFF_CTRL && wStrb_r[0])
            extEn_r <= wData_r[CTRL_EXT_BIT];
         if (awAddr_r == OFF_BANK)
            bank_r <= 4'(mergeLanes({28'h000_0000, bank_r}, wData_r, wStrb_r));
         if (awAddr_r == OFF_INDEX)
            indexBase_r <= 12'(mergeLanes({20'h0_0000, indexBase_r}, wData_r, wStrb_r));
      end
   end

   // instruction decode
   always_comb
   begin
      opDecoded = OP_NONE;
      if (instrIn.word[15:9] == OPC_LESS)
         opDecoded = OP_LESS;
      else if (instrIn.word[15:9] == OPC_EQUAL)
         opDecoded = OP_EQUAL;
      else if (instrIn.word[15:9] == OPC_GREATER)
         opDecoded = OP_GREATER;
      else if (instrIn.word == WORD_DAW)
         opDecoded = OP_DAW;
   end

   // operand address resolution
   always_comb
   begin
      if (access_r)
         effAddr = {bank_r, file_r};
      else if (extEn_r && (file_r <= INDEXED_MAX))
         effAddr = 12'(indexBase_r + {4'h0, file_r});
      else if (file_r > INDEXED_MAX)
         effAddr = {ACCESS_HIGH_BANK, file_r};
      else
         effAddr = {4'h0, file_r};
   end

   assign isCompare = (op_r == OP_LESS) || (op_r == OP_EQUAL) || (op_r == OP_GREATER);
   assign decide    = qTick && (qPhase == Q_FOUR) && (state_r == S_EXEC);
   assign dawCommit = decide && (op_r == OP_DAW);

   // instruction sequencing on quarter phases
   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         state_r   <= S_IDLE;
         op_r      <= OP_NONE;
         file_r    <= 8'h00;
         access_r  <= 1'b0;
         twoWord_r <= 1'b0;
         nopLeft_r <= 2'd0;
         operand_r <= 8'h00;
      end
      else if (qTick)
      begin
         case (state_r)
            S_IDLE:
               if (qPhase == Q_ONE && instrIn.valid && opDecoded != OP_NONE)
               begin
                  state_r   <= S_EXEC;
                  op_r      <= opDecoded;
                  access_r  <= instrIn.word[8];
                  file_r    <= instrIn.word[7:0];
                  twoWord_r <= instrIn.nextTwoWord;
               end
            S_EXEC:
            begin
               if (qPhase == Q_THREE && isCompare)
                  operand_r <= memRdData;
               if (qPhase == Q_FOUR)
               begin
                  if (isCompare && skipHit)
                  begin
                     state_r   <= S_SKIP;
                     nopLeft_r <= twoWord_r ? NOP_TWO_WORD : NOP_ONE_WORD;
                  end
                  else
                     state_r <= S_IDLE;
               end
            end
            S_SKIP:
               if (qPhase == Q_FOUR)
               begin
                  if (nopLeft_r == NOP_ONE_WORD)
                     state_r <= S_IDLE;
                  else
                     nopLeft_r <= nopLeft_r - 2'd1;
               end
            default: state_r <= S_IDLE;
         endcase
      end
   end

   // working register: decimal adjust wins over a software write
   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
         work_r <= RST_WORK;
      else if (dawCommit)
         work_r <= dawValue;
      else if (doWrite && awAddr_r == OFF_WORK && wStrb_r[0])
         work_r <= wData_r[7:0];
   end

   // flags: compares never touch them, decimal adjust updates carry only
   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         carry_r      <= 1'b0;
         digitCarry_r <= 1'b0;
      end
      else
      begin
         if (dawCommit)
            carry_r <= dawCarry;
         else if (doWrite && awAddr_r == OFF_FLAGS && wStrb_r[0])
            carry_r <= wData_r[FLAG_C_BIT];
         if (doWrite && awAddr_r == OFF_FLAGS && wStrb_r[0])
            digitCarry_r <= wData_r[FLAG_DC_BIT];
      end
   end

   // skip history
   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         lastSkip_r  <= 1'b0;
         skipCount_r <= 16'h0000;
      end
      else if (decide && isCompare)
      begin
         lastSkip_r <= skipHit;
         if (skipHit)
            skipCount_r <= skipCount_r + 16'h0001;
      end
   end

   // pipeline outputs, all registered
   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
         pipeOut <= '0;
      else
      begin
         pipeOut.ready   <= (state_r == S_IDLE);
         pipeOut.busy    <= (state_r != S_IDLE);
         pipeOut.discard <= decide && isCompare && skipHit;
         pipeOut.memRdEn <= qTick && (qPhase == Q_TWO) && (state_r == S_EXEC) && isCompare;
         pipeOut.memAddr <= effAddr;
      end
   end

endmodule

// ===== tb/csda_core_props.sv
`timescale 1ns/10ps
module csda_core_props #(
   parameter int Q_DIV = 4
) (
   input wire logic               sys_clk,
   input wire logic               rst,
   input wire logic               s_axi_awvalid,
   input wire logic               s_axi_awready,
   input wire logic               s_axi_wvalid,
   input wire logic               s_axi_wready,
   input wire logic [1:0]         s_axi_bresp,
   input wire logic               s_axi_bvalid,
   input wire logic               s_axi_bready,
   input wire logic               s_axi_arvalid,
   input wire logic               s_axi_arready,
   input wire logic [31:0]        s_axi_rdata,
   input wire logic [1:0]         s_axi_rresp,
   input wire logic               s_axi_rvalid,
   input wire logic               s_axi_rready,
   input csda_pkg::csda_pipe_type pipeOut
);
   import csda_pkg::*;

   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (rst);

   property p_discard_pulse;
      pipeOut.discard |=> !pipeOut.discard [*8];
   endproperty
   a_discard_pulse: assert property (p_discard_pulse)
      else $error("discard longer than one clock");

   property p_discard_busy;
      pipeOut.discard |-> pipeOut.busy && !pipeOut.ready;
   endproperty
   a_discard_busy: assert property (p_discard_busy)
      else $error("discard outside a busy instruction");

   property p_discard_timing;
      $rose(pipeOut.discard) |-> $past(pipeOut.memRdEn, 2 * Q_DIV);
   endproperty
   a_discard_timing: assert property (p_discard_timing)
      else $error("discard not two quarters after operand read");

   property p_nop_hold;
      pipeOut.discard |=> pipeOut.busy [*8];
   endproperty
   a_nop_hold: assert property (p_nop_hold)
      else $error("skip nop cycle cut short");

   property p_read_gap;
      pipeOut.memRdEn |=> !pipeOut.memRdEn [*8];
   endproperty
   a_read_gap: assert property (p_read_gap)
      else $error("second operand read within one instruction");

   property p_read_busy;
      pipeOut.memRdEn |-> pipeOut.busy && !pipeOut.ready;
   endproperty
   a_read_busy: assert property (p_read_busy)
      else $error("operand read while idle");

   property p_ready_busy;
      !(pipeOut.ready && pipeOut.busy);
   endproperty
   a_ready_busy: assert property (p_ready_busy)
      else $error("ready and busy together");

   property p_write_answer;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> ##1 s_axi_bvalid;
   endproperty
   a_write_answer: assert property (p_write_answer)
      else $error("no write response after address and data");

   property p_read_answer;
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
   endproperty
   a_read_answer: assert property (p_read_answer)
      else $error("no read data after address");

   property p_b_hold;
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
   endproperty
   a_b_hold: assert property (p_b_hold)
      else $error("write response dropped early");

   property p_r_hold;
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp);
   endproperty
   a_r_hold: assert property (p_r_hold)
      else $error("read data dropped early");

   c_discard: cover property (pipeOut.discard);
   c_read: cover property (pipeOut.memRdEn);
   c_write: cover property (s_axi_bvalid && s_axi_bready);
endmodule

bind csda_core csda_core_props #(.Q_DIV(Q_DIV)) i_csda_core_props (
   .sys_clk(sys_clk), .rst(rst), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
   .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
   .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
   .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
   .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .pipeOut(pipeOut));

// ===== tb/compare_skip_and_decimal_adjust_tb_top.sv
`timescale 1ns/10ps
module compare_skip_and_decimal_adjust_tb_top;
   import csda_pkg::*;
   localparam int QD = 3;
   logic           sys_clk;
   logic           rst;
   logic [7:0]     s_axi_awaddr;
   logic           s_axi_awvalid;
   logic           s_axi_awready;
   logic [31:0]    s_axi_wdata;
   logic [3:0]     s_axi_wstrb;
   logic           s_axi_wvalid;
   logic           s_axi_wready;
   logic [1:0]     s_axi_bresp;
   logic           s_axi_bvalid;
   logic           s_axi_bready;
   logic [7:0]     s_axi_araddr;
   logic           s_axi_arvalid;
   logic           s_axi_arready;
   logic [31:0]    s_axi_rdata;
   logic [1:0]     s_axi_rresp;
   logic           s_axi_rvalid;
   logic           s_axi_rready;
   csda_instr_type instrIn;
   csda_pipe_type  pipeOut;
   logic [7:0]     memRdData;
   int             fails;
   int             numChecks;
   logic [31:0]    rd;
   logic [1:0]     rsp;
   int             cyc;
   logic           disc;
   logic           two;
   logic           hit;
   logic [11:0]    addr;
   logic [8:0]     exp9;
   logic [7:0]     fileTab [4] = '{8'h10, 8'h5F, 8'h60, 8'h20};
   logic           extTab [4]  = '{1'b1, 1'b1, 1'b1, 1'b0};
   logic [11:0]    addrTab [4] = '{12'h008, 12'h057, 12'hF60, 12'h020};
   logic [7:0]     dawW [5]    = '{8'hA5, 8'h99, 8'h12, 8'h3A, 8'h9A};
   logic           dawC [5]    = '{1'b0, 1'b0, 1'b1, 1'b0, 1'b0};
   logic           dawD [5]    = '{1'b0, 1'b1, 1'b0, 1'b0, 1'b0};

   csda_core #(.Q_DIV(QD)) i_csda_core (
      .sys_clk(sys_clk), .rst(rst), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
      .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
      .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
      .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
      .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
      .instrIn(instrIn), .pipeOut(pipeOut), .memRdData(memRdData));

   task automatic report_and_stop;
      if (fails == 0 && numChecks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] want);
      numChecks++;
      if (seen !== want)
      begin
         fails++;
         $display("MISMATCH at %0t: seen %h expected %h", $time, seen, want);
      end
   endtask

   task automatic axiWrite(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      int n;
      n = 0;
      r = 2'b11;
      @(posedge sys_clk);
      s_axi_awaddr  <= a;
      s_axi_awvalid <= 1'b1;
      s_axi_wdata   <= d;
      s_axi_wvalid  <= 1'b1;
      s_axi_bready  <= 1'b1;
      while (n < 100)
      begin
         @(posedge sys_clk);
         n++;
         if (s_axi_awready)
            s_axi_awvalid <= 1'b0;
         if (s_axi_wready)
            s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid)
         begin
            r = s_axi_bresp;
            s_axi_bready <= 1'b0;
            n = 1000;
         end
      end
      if (n < 1000)
         fails++;
   endtask

   task automatic axiRead(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      int n;
      n = 0;
      d = 32'hFFFF_FFFF;
      r = 2'b11;
      @(posedge sys_clk);
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready  <= 1'b1;
      while (n < 100)
      begin
         @(posedge sys_clk);
         n++;
         if (s_axi_arready)
            s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid)
         begin
            d = s_axi_rdata;
            r = s_axi_rresp;
            s_axi_rready <= 1'b0;
            n = 1000;
         end
      end
      if (n < 1000)
         fails++;
   endtask

   // offers one instruction, returns instruction cycles, skip and operand address
   task automatic runInstr(input logic [15:0] w, input logic t, output int c,
                           output logic ds, output logic [11:0] ad);
      int n;
      int b;
      n = 0;
      b = 0;
      ds = 1'b0;
      ad = 12'hFFF;
      @(posedge sys_clk);
      instrIn <= '{1'b1, w, t};
      while (pipeOut.busy !== 1'b1 && n < 100)
      begin
         @(posedge sys_clk);
         n++;
      end
      instrIn.valid <= 1'b0;
      while (pipeOut.busy === 1'b1 && n < 400)
      begin
         if (pipeOut.discard === 1'b1)
            ds = 1'b1;
         if (pipeOut.memRdEn === 1'b1)
            ad = pipeOut.memAddr;
         b++;
         @(posedge sys_clk);
         n++;
      end
      if (n >= 100 && b == 0 || n >= 400)
         fails++;
      c = (b + 2 * QD) / (4 * QD);
   endtask

   function automatic logic [8:0] dawRef(input logic [7:0] w, input logic c, input logic dc);
      logic [4:0] lo;
      logic [4:0] hi;
      lo = {1'b0, w[3:0]};
      if (w[3:0] > 4'h9 || dc)
         lo = lo + 5'h06;
      hi = {1'b0, w[7:4]} + {4'h0, dc};
      if (hi > 5'h09 || c)
         hi = hi + 5'h06;
      return {hi[4] | c, hi[3:0], lo[3:0]};
   endfunction

   initial
   begin
      sys_clk = 1'b0;
      forever #25 sys_clk = ~sys_clk;
   end

   initial
   begin
      repeat (20000) @(posedge sys_clk);
      fails++;
      report_and_stop();
   end

   initial
   begin
      fails = 0;
      numChecks = 0;
      rst = 1'b1;
      s_axi_awaddr = 8'h00;
      s_axi_awvalid = 1'b0;
      s_axi_wdata = 32'h0000_0000;
      s_axi_wstrb = 4'hF;
      s_axi_wvalid = 1'b0;
      s_axi_bready = 1'b0;
      s_axi_araddr = 8'h00;
      s_axi_arvalid = 1'b0;
      s_axi_rready = 1'b0;
      instrIn = '{1'b0, 16'h0000, 1'b0};
      memRdData = 8'h00;
      repeat (10) @(posedge sys_clk);
      rst <= 1'b0;
      repeat (2) @(posedge sys_clk);
      for (int i = 0; i < 7; i++)
      begin
         axiRead(8'(i * 4), rd, rsp);
         check(rd, 32'h0000_0000);
      end
      axiRead(8'h1C, rd, rsp);
      check({rd[29:0], rsp}, {30'h0, RESP_SLVERR});
      axiWrite(8'h1C, 32'h0000_00FF, rsp);
      check({30'h0, rsp}, {30'h0, RESP_SLVERR});
      axiWrite(OFF_SKIPS, 32'h0000_FFFF, rsp);
      axiWrite(OFF_WORK, 32'h0000_0080, rsp);
      axiWrite(OFF_FLAGS, 32'h0000_0003, rsp);
      axiWrite(OFF_BANK, 32'h0000_0005, rsp);
      // unsigned compares around the working value, every opcode
      for (int i = 0; i < 3; i++)
         for (int j = 0; j < 3; j++)
         begin
            memRdData <= 8'h7F + 8'(j);
            two = (i != 0);
            hit = (i == j);
            runInstr({OPC_LESS + 7'(i), 1'b1, 8'h42}, two, cyc, disc, addr);
            check(32'(disc), 32'(hit));
            check(32'(cyc), 32'(hit ? (two ? 3 : 2) : 1));
            check(32'(addr), 32'h0000_0542);
            axiRead(OFF_STATE, rd, rsp);
            check(rd, {16'h0, 8'h7F + 8'(j), 6'h00, hit, 1'b0});
         end
      axiRead(OFF_WORK, rd, rsp);
      check({rd[29:0], rsp}, {30'h0000_0080, RESP_OKAY});
      axiRead(OFF_FLAGS, rd, rsp);
      check(rd, 32'h0000_0003);
      axiRead(OFF_SKIPS, rd, rsp);
      check(rd, 32'h0000_0003);
      axiWrite(OFF_INDEX, 32'h0000_0FF8, rsp);
      for (int k = 0; k < 4; k++)
      begin
         axiWrite(OFF_CTRL, 32'(extTab[k]), rsp);
         runInstr({OPC_EQUAL, 1'b0, fileTab[k]}, 1'b0, cyc, disc, addr);
         check({18'h0, rsp, addr}, {18'h0, RESP_OKAY, addrTab[k]});
      end
      @(posedge sys_clk);
      instrIn <= '{1'b1, 16'h6600, 1'b0};
      cyc = 0;
      repeat (8 * QD)
      begin
         @(posedge sys_clk);
         cyc = cyc + int'(pipeOut.busy);
      end
      instrIn.valid <= 1'b0;
      check(32'(cyc), 32'h0000_0000);
      for (int k = 0; k < 5; k++)
      begin
         axiWrite(OFF_WORK, 32'(dawW[k]), rsp);
         axiWrite(OFF_FLAGS, {30'h0, dawD[k], dawC[k]}, rsp);
         runInstr(WORD_DAW, 1'b0, cyc, disc, addr);
         exp9 = dawRef(dawW[k], dawC[k], dawD[k]);
         check(32'(cyc), 32'h0000_0001);
         axiRead(OFF_WORK, rd, rsp);
         check(rd, 32'(exp9[7:0]));
         axiRead(OFF_FLAGS, rd, rsp);
         check(rd, {30'h0, dawD[k], exp9[8]});
      end
      report_and_stop();
   end
endmodule
